/* common/flash_poll_pkg.sv */
/*
 * Constants, state codes and timing for the flash status poller.
 * Assumes a 50 MHz system clock and an 8-bit flash data bus.
 */
package flash_poll_pkg;
    // System clock rate and bus cycle timing.
    localparam int CLK_MHZ = 50;
    localparam int T_STROBE_NS = 70;
    localparam int T_RECOV_NS = 30;
    // Least times round up to whole cycles.
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOV_CYC = (T_RECOV_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 4;
    // Strobe stays low long enough for data to pass the synchroniser.
    localparam logic [CNT_W-1:0] HOLD_CNT =
        CNT_W'(STROBE_CYC + SYNC_STAGES - 1);
    localparam logic [CNT_W-1:0] RECOV_CNT = CNT_W'(RECOV_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    // Status bit positions on the data bus.
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int FAIL_BIT = 5;
    localparam int SECTOR_BIT = 2;

    // Reset command that returns the device to array reads.
    localparam logic [7:0] RESET_CMD = 8'hF0;

    // Polling modes.
    localparam logic MODE_DATA = 1'b0;
    localparam logic MODE_TOGGLE = 1'b1;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_FIRST = 6'h02,
        S_SECOND = 6'h04,
        S_RECHECK = 6'h08,
        S_FINAL = 6'h10,
        S_RESET = 6'h20
    } poll_state_e;

    typedef enum logic [2:0] {
        CY_IDLE = 3'h1,
        CY_STROBE = 3'h2,
        CY_RECOV = 3'h4
    } cycle_state_e;
endpackage : flash_poll_pkg

/* src/flash_bus_cycle.sv */
/*
 * One read or write cycle on the flash pins, with a two-stage
 * synchroniser on the data inputs. Assumes the caller starts a new
 * cycle only after done, and that the pins are in another time domain.
 */
`timescale 1ns/1ps
module flash_bus_cycle
    import flash_poll_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input wire logic write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in
);
    cycle_state_e state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [DATA_W-1:0] dq_meta_ff, dq_sync_ff;
    logic done_ff, ce_n_ff, oe_n_ff, we_n_ff, dq_oe_ff;
    logic [DATA_W-1:0] rdata_ff, dq_out_ff;
    logic [ADDR_W-1:0] addr_out_ff;

    wire cnt_end = (cnt_ff == CNT_ZERO);
    wire go = (state_ff == CY_IDLE) && start;

    // Data pins cross into the clock domain through two flops.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dq_meta_ff <= '0;
            dq_sync_ff <= '0;
        end else begin
            dq_meta_ff <= dq_in;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // Cycle sequencer: strobe phase, then recovery before done.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= CY_IDLE;
            cnt_ff <= CNT_ZERO;
            done_ff <= 1'b0;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            dq_oe_ff <= 1'b0;
            rdata_ff <= '0;
            dq_out_ff <= '0;
            addr_out_ff <= '0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                CY_IDLE: if (go) begin
                    addr_out_ff <= addr;
                    dq_out_ff <= wdata;
                    dq_oe_ff <= write;
                    ce_n_ff <= 1'b0;
                    oe_n_ff <= write;
                    we_n_ff <= !write;
                    cnt_ff <= HOLD_CNT;
                    state_ff <= CY_STROBE;
                end
                CY_STROBE: if (cnt_end) begin
                    // Sampled before release, so read data is stable.
                    rdata_ff <= dq_sync_ff;
                    ce_n_ff <= 1'b1;
                    oe_n_ff <= 1'b1;
                    we_n_ff <= 1'b1;
                    cnt_ff <= RECOV_CNT;
                    state_ff <= CY_RECOV;
                end else begin
                    cnt_ff <= cnt_ff - 4'h1;
                end
                CY_RECOV: if (cnt_end) begin
                    // Data is held past the write strobe for hold time.
                    dq_oe_ff <= 1'b0;
                    done_ff <= 1'b1;
                    state_ff <= CY_IDLE;
                end else begin
                    cnt_ff <= cnt_ff - 4'h1;
                end
            endcase
        end
    end

    assign done = done_ff;
    assign rdata = rdata_ff;
    assign ce_n = ce_n_ff;
    assign oe_n = oe_n_ff;
    assign we_n = we_n_ff;
    assign addr_out = addr_out_ff;
    assign dq_out = dq_out_ff;
    assign dq_oe = dq_oe_ff;

    strobe_width_a: assert property (@(posedge clock) disable iff (!resetn)
        $fell(oe_n_ff) |-> !oe_n_ff [*6])
        else $error("Read strobe shorter than the access hold.");
endmodule : flash_bus_cycle

/* src/flash_status_poller.sv */
/*
 * Host-side poller for a parallel flash write operation: data polling
 * on the complement bit or toggle polling, with failure recovery.
 * Assumes the user starts it after the last write of the program or
 * erase command and gives a valid status address.
 */
`timescale 1ns/1ps
module flash_status_poller
    import flash_poll_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input wire logic mode,
    input wire logic [ADDR_W-1:0] valid_status_address,
    input wire logic [DATA_W-1:0] expect_data,
    input wire logic abort,
    output logic busy,
    output logic pass,
    output logic fail,
    output logic aborted,
    output logic [DATA_W-1:0] result_data,
    output logic sector_toggling,
    output logic device_ready,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic ready_busy_out_n
);
    poll_state_e state_ff, nxt_state;
    logic issue_ff, nxt_issue;
    logic mode_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] exp_ff, prev_ff, result_ff;
    logic busy_ff, pass_ff, fail_ff, aborted_ff, sector_tog_ff;
    logic rb_meta_ff, ready_ff;
    logic cyc_done;
    logic [DATA_W-1:0] rdata;

    // True when bit pos differs between two bytes.
    function automatic logic bit_differs(input logic [DATA_W-1:0] a,
                                         input logic [DATA_W-1:0] b,
                                         input int pos);
        bit_differs = a[pos] ^ b[pos];
    endfunction : bit_differs

    // Status decode of the byte just read.
    wire poll_match = !bit_differs(rdata, exp_ff, POLL_BIT);
    wire toggled = bit_differs(rdata, prev_ff, TOGGLE_BIT);
    wire sector_tog = bit_differs(rdata, prev_ff, SECTOR_BIT);
    wire fail_seen = rdata[FAIL_BIT];
    wire is_toggle = (mode_ff == MODE_TOGGLE);
    wire recheck_ok = is_toggle ? !toggled : poll_match;
    wire cyc_write = (state_ff == S_RESET);
    wire in_loop = (state_ff == S_FIRST) || (state_ff == S_SECOND);

    // Polling sequence; abort is honoured only between reads so the
    // pins never see a cut-short strobe.
    always_comb begin
        nxt_state = state_ff;
        nxt_issue = 1'b0;
        unique case (state_ff)
            S_IDLE: if (start) begin
                nxt_state = S_FIRST;
                nxt_issue = 1'b1;
            end
            S_FIRST: if (cyc_done) begin
                nxt_issue = !abort;
                if (abort) begin
                    nxt_state = S_IDLE;
                end else if (is_toggle) begin
                    nxt_state = S_SECOND;
                end else if (poll_match) begin
                    nxt_state = S_FINAL;
                end else if (fail_seen) begin
                    nxt_state = S_RECHECK;
                end
            end
            S_SECOND: if (cyc_done) begin
                nxt_issue = !abort;
                if (abort) begin
                    nxt_state = S_IDLE;
                end else if (!toggled) begin
                    nxt_state = S_FINAL;
                end else if (fail_seen) begin
                    nxt_state = S_RECHECK;
                end
            end
            S_RECHECK: if (cyc_done) begin
                nxt_issue = 1'b1;
                nxt_state = recheck_ok ? S_FINAL : S_RESET;
            end
            S_FINAL: if (cyc_done) begin
                nxt_state = S_IDLE;
            end
            S_RESET: if (cyc_done) begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // State, request pulse and the captured order.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= S_IDLE;
            issue_ff <= 1'b0;
            mode_ff <= MODE_DATA;
            addr_ff <= '0;
            exp_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            issue_ff <= nxt_issue;
            if (state_ff == S_IDLE && start) begin
                mode_ff <= mode;
                addr_ff <= valid_status_address;
                exp_ff <= expect_data;
            end
        end
    end

    // Previous byte for toggle compare, and result reporting.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_ff <= '0;
            result_ff <= '0;
            busy_ff <= 1'b0;
            pass_ff <= 1'b0;
            fail_ff <= 1'b0;
            aborted_ff <= 1'b0;
            sector_tog_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != S_IDLE);
            pass_ff <= (state_ff == S_FINAL) && cyc_done;
            fail_ff <= cyc_write && cyc_done;
            aborted_ff <= in_loop && cyc_done && abort;
            if (cyc_done && !cyc_write) begin
                prev_ff <= rdata;
            end
            if (state_ff == S_FINAL && cyc_done) begin
                result_ff <= rdata;
            end
            if (state_ff == S_IDLE && start) begin
                sector_tog_ff <= 1'b0;
            end else if (cyc_done && !cyc_write &&
                         state_ff != S_FIRST) begin
                sector_tog_ff <= sector_tog;
            end
        end
    end

    // Ready/busy pin is asynchronous; two flops before use.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rb_meta_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            rb_meta_ff <= ready_busy_out_n;
            ready_ff <= rb_meta_ff;
        end
    end

    flash_bus_cycle #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_cycle (
        .clock(clock),
        .resetn(resetn),
        .start(issue_ff),
        .write(cyc_write),
        .addr(addr_ff),
        .wdata(RESET_CMD),
        .done(cyc_done),
        .rdata(rdata),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .addr_out(addr_out),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .dq_in(dq_in)
    );

    assign busy = busy_ff;
    assign pass = pass_ff;
    assign fail = fail_ff;
    assign aborted = aborted_ff;
    assign result_data = result_ff;
    assign sector_toggling = sector_tog_ff;
    assign device_ready = ready_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    status_addr_a: assert property (
        $fell(oe_n) |-> addr_out == addr_ff)
        else $error("Status read not at the valid status address.");
    final_read_a: assert property (
        state_ff == S_FIRST && cyc_done && !is_toggle && poll_match
        && !abort |=> state_ff == S_FINAL ##[1:40] pass_ff)
        else $error("No extra read after the polled bit turned true.");
    pass_origin_a: assert property (
        pass_ff |-> $past(state_ff) == S_FINAL)
        else $error("Pass reported without a final data read.");
    fail_recheck_a: assert property (
        state_ff == S_FIRST && cyc_done && !is_toggle && !poll_match
        && fail_seen && !abort |=> state_ff == S_RECHECK)
        else $error("Polled bit not re-read after the failure flag.");
    double_read_a: assert property (
        state_ff == S_FIRST && cyc_done && is_toggle && !abort
        |=> state_ff == S_SECOND ##[1:40] cyc_done)
        else $error("Toggle polling did not make a second read.");
    reset_cmd_a: assert property (
        $rose(state_ff == S_RESET)
        |-> ##[1:40] (!we_n && dq_oe && dq_out == RESET_CMD))
        else $error("Reset command not written after failure.");
    fail_origin_a: assert property (
        fail_ff |-> $past(state_ff) == S_RESET)
        else $error("Fail reported without a reset command.");
    restart_a: assert property (
        state_ff == S_IDLE && start |=> state_ff == S_FIRST && issue_ff)
        else $error("Polling did not restart from the first read.");

    pass_seen_c: cover property (pass_ff && is_toggle);
    fail_seen_c: cover property (fail_ff);
    abort_seen_c: cover property (aborted_ff);
endmodule : flash_status_poller

/* tb/flash_device_model.sv */
/*
 * Behavioural model of the flash device on the far side of the poller.
 * Assumes the bench starts each internal operation with begin_op and
 * resolves the data bus and the pulled-up ready/busy pin itself.
 */
`timescale 1ns/1ps
module flash_device_model (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    output logic [7:0] dev_dq,
    output logic rb_low
);
    logic [7:0] array_byte = 8'h5A;
    logic [7:0] new_array = 8'h5A;
    logic [7:0] pend = 8'h00;
    logic [7:0] shown = 8'h00;
    logic t6 = 1'b0;
    logic t2 = 1'b0;
    logic erase_op = 1'b0;
    logic susp = 1'b0;
    int rd_count = 0;
    int done_n = 0;
    int fail_n = 1000;

    // Status is shown from the moment the operation starts.
    wire rd = !ce_n && !oe_n;
    wire active = rd_count < done_n;
    wire fail_now = rd_count >= fail_n;
    // A suspended erase holds the first toggle bit and frees the pin,
    // while programming inside a suspend behaves like any program.
    wire held = erase_op && susp;
    wire poll_bit = erase_op ? susp : ~pend[7];
    wire [7:0] status = {poll_bit, t6, fail_now, 2'h0, t2, 2'h0};

    // Released bus shows the inverse so a stale byte never looks valid.
    assign dev_dq = rd ? shown : ~shown;
    assign rb_low = active && !held;

    // Byte is frozen for the whole read cycle.
    always @(posedge rd) begin
        shown = active ? status : array_byte;
    end

    // Toggle bits advance at the end of each status read; t6 stops while held, t2 moves in erase only.
    always @(negedge rd) begin
        if (active) begin
            rd_count++;
            if (!held) t6 = ~t6;
            if (erase_op) t2 = ~t2;
            if (rd_count == done_n) array_byte = new_array;
        end
    end

    // The reset command ends a failed operation.
    always @(posedge we_n) begin
        if (dq_oe && dq_out == 8'hF0) done_n = rd_count;
    end

    task automatic begin_op(input logic e, input logic s, input logic p,
        input logic [7:0] d, input int dn, input int fn);
        erase_op = e;
        susp = s;
        pend = d;
        new_array = p ? array_byte : (e ? 8'hFF : d);
        t6 = 1'b0;
        t2 = 1'b0;
        rd_count = 0;
        fail_n = fn;
        done_n = dn;
    endtask : begin_op
endmodule : flash_device_model

/* tb/tb_flash_status_poller.sv */
/*
 * Self-checking bench for the flash status poller.
 * Assumes the behavioural device model and the package constants.
 */
`timescale 1ns/1ps
module tb_flash_status_poller;
    import flash_poll_pkg::*;
    typedef struct packed {logic [2:0] kind; logic [7:0] data;} note_s;
    logic clock, resetn, start, mode, abort, busy, pass, fail, aborted;
    logic sector_toggling, device_ready, ce_n, oe_n, we_n, dq_oe, rb_low;
    logic [20:0] vaddr, addr_out;
    logic [7:0] expect_data, result_data, dq_out, dev_dq, d, arr;
    logic [31:0] lfsr_ff;
    note_s notes[$];
    note_s got;
    logic [2:0] end_flags;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    wire rb_wire = rb_low ? 1'b0 : 1'b1;
    wire [7:0] dq_in = dq_oe ? dq_out : dev_dq;

    flash_status_poller flash_status_poller_i (.clock(clock),
        .resetn(resetn), .start(start), .mode(mode),
        .valid_status_address(vaddr), .expect_data(expect_data),
        .abort(abort), .busy(busy), .pass(pass), .fail(fail),
        .aborted(aborted), .result_data(result_data),
        .sector_toggling(sector_toggling), .device_ready(device_ready),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr_out(addr_out),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .ready_busy_out_n(rb_wire));
    flash_device_model flash_device_model_i (.ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe), .dev_dq(dev_dq),
        .rb_low(rb_low));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic rnd_byte(output logic [7:0] v);
        lfsr_ff = lfsr_next(lfsr_ff);
        v = lfsr_ff[7:0];
    endtask : rnd_byte

    task automatic compare_byte(input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask : compare_byte

    task automatic compare_bit(input logic e, input logic g);
        compare_byte({7'h00, e}, {7'h00, g});
    endtask : compare_bit

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // One poll; a second start while busy must be ignored.
    task automatic poll(input logic m, input logic [2:0] k,
        input logic [7:0] r);
        int i;
        notes.push_back(note_s'{k, r});
        @(posedge clock);
        start <= 1'b1;
        mode <= m;
        expect_data <= d;
        vaddr <= lfsr_ff[20:0];
        @(posedge clock);
        start <= 1'b0;
        repeat (3) @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        for (i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clock);
        repeat (2) @(posedge clock);
        $display("Poll in mode %0d finished at %0t", m, $time);
    endtask : poll

    // The queue holds one note for every end pulse the driver expects;
    // an empty queue gives a zero note, so a stray pulse is a mismatch.
    always @(posedge clock) begin
        if (resetn === 1'b1 && ce_n === 1'b0) begin
            compare_bit(1'b0, |(addr_out ^ vaddr));
        end
        end_flags = {pass, fail, aborted};
        if (resetn === 1'b1 && end_flags !== 3'h0) begin
            got = '0;
            if (notes.size() > 0) begin
                got = notes.pop_front();
            end
            compare_byte({5'h00, got.kind}, {5'h00, end_flags});
            if (got.kind[2]) begin
                compare_byte(got.data, result_data);
            end
        end
    end

    // Hang guard, far above the several hundred cycles the run needs.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        resetn = 1'b0;
        start = 1'b0;
        mode = 1'b0;
        abort = 1'b0;
        vaddr = 21'h000000;
        expect_data = 8'h00;
        lfsr_ff = 32'hB5EE;
        arr = 8'h5A;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        rnd_byte(d);
        flash_device_model_i.begin_op(0, 0, 0, d, 4, 1000);
        repeat (4) @(posedge clock);
        compare_bit(1'b0, device_ready);
        poll(MODE_DATA, 3'b100, d);
        compare_bit(1'b1, device_ready);
        rnd_byte(d);
        flash_device_model_i.begin_op(0, 0, 0, d, 3, 1000);
        poll(MODE_TOGGLE, 3'b100, d);
        d = 8'hFF;
        flash_device_model_i.begin_op(1, 0, 0, d, 3, 1000);
        poll(MODE_DATA, 3'b100, 8'hFF);
        flash_device_model_i.begin_op(1, 1, 0, d, 1000, 1000);
        poll(MODE_TOGGLE, 3'b100, 8'h80);
        compare_bit(1'b1, sector_toggling);
        rnd_byte(d);
        flash_device_model_i.begin_op(0, 0, 0, d, 2, 1);
        poll(MODE_DATA, 3'b100, d);
        arr = d;
        rnd_byte(d);
        flash_device_model_i.begin_op(0, 0, 0, d, 1000, 1);
        poll(MODE_DATA, 3'b010, 8'h00);
        compare_bit(1'b1, device_ready);
        d = 8'hFF;
        flash_device_model_i.begin_op(1, 0, 0, d, 1000, 1);
        poll(MODE_TOGGLE, 3'b010, 8'h00);
        rnd_byte(d);
        flash_device_model_i.begin_op(0, 0, 1, d, 2, 1000);
        poll(MODE_TOGGLE, 3'b100, arr);
        flash_device_model_i.begin_op(1, 0, 1, 8'hFF, 3, 1000);
        poll(MODE_TOGGLE, 3'b100, arr);
        abort <= 1'b1;
        flash_device_model_i.begin_op(0, 0, 0, d, 1000, 1000);
        poll(MODE_DATA, 3'b001, 8'h00);
        abort <= 1'b0;
        flash_device_model_i.begin_op(0, 1, 0, d, 3, 1000);
        poll(MODE_TOGGLE, 3'b100, d);
        compare_byte(8'h00, 8'(notes.size()));
        results();
    end
endmodule : tb_flash_status_poller
